/* File: core/duc_pkg.sv */
// Package with constants and carrier types for the converter update and reset control block.
package duc_pkg;

    localparam int unsigned NUM_CHAN   = 2;
    localparam int unsigned CODE_W     = 12;
    localparam int unsigned WORD_W     = 24;
    localparam int unsigned CMD_MSB    = 23;
    localparam int unsigned CMD_LSB    = 20;
    localparam int unsigned ADDR_MSB   = 19;
    localparam int unsigned ADDR_LSB   = 16;
    localparam int unsigned DATA_MSB   = 15;
    localparam int unsigned DATA_LSB   = 4;
    localparam int unsigned MASK_B_BIT = 3;
    localparam int unsigned MASK_A_BIT = 0;
    localparam int unsigned REF_BIT    = 0;

    localparam logic [3:0] CMD_WR_INPUT  = 4'h1;
    localparam logic [3:0] CMD_UPD_DAC   = 4'h2;
    localparam logic [3:0] CMD_WR_UPD    = 4'h3;
    localparam logic [3:0] CMD_LOAD_MASK = 4'h5;
    localparam logic [3:0] CMD_SOFT_RST  = 4'h6;
    localparam logic [3:0] CMD_REF_SETUP = 4'h7;

    // Address bits: bit 0 selects channel A, bit 3 selects channel B.
    localparam int unsigned ADDR_A_BIT = 0;
    localparam int unsigned ADDR_B_BIT = 3;

    localparam logic [11:0] CODE_ZERO = 12'h000;
    localparam logic [11:0] CODE_MID  = 12'h800;
    localparam logic        REF_DIS_RESET  = 1'h0;
    localparam logic [1:0]  MASK_RESET     = 2'h0;

    // Minimum low time of the reset pin, and power-on settle time.
    localparam int unsigned RST_MIN_NS   = 30;
    localparam int unsigned CLK_NS       = 10;
    localparam int unsigned RST_MIN_CYC  = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned POR_NS       = 160;
    localparam int unsigned POR_CYC      = (POR_NS + CLK_NS - 1) / CLK_NS;

    typedef struct packed {
        logic [3:0]  cmd;
        logic [3:0]  addr;
        logic [15:0] data;
    } duc_word_type;

    typedef struct packed {
        logic [1:0]        chan_sel;
        logic [11:0]       code;
    } duc_write_type;

endpackage : duc_pkg

/* File: core/duc_channel.sv */
// One converter channel: input register and DAC register with their update paths.
`timescale 1ns/100ps
module duc_channel (
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic        ce_i,
    input  wire logic        clear_i,
    input  wire logic [11:0] clear_code_i,
    input  wire logic        load_input_i,
    input  wire logic        load_dac_new_i,
    input  wire logic        copy_i,
    input  wire logic [11:0] code_i,
    output logic      [11:0] input_code_o,
    output logic      [11:0] dac_code_o
);
    logic [11:0] inp_q;
    logic [11:0] inp_d;
    logic [11:0] dac_q;
    logic [11:0] dac_d;

    always_comb begin
        inp_d = inp_q;
        dac_d = dac_q;
        if (clear_i) begin
            inp_d = clear_code_i;
            dac_d = clear_code_i;
        end else begin
            if (load_input_i) begin
                inp_d = code_i;
            end
            // A new word wins over a copy of the old input value.
            if (load_dac_new_i) begin
                dac_d = code_i;
            end else if (copy_i) begin
                dac_d = inp_q;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            inp_q <= duc_pkg::CODE_ZERO;
            dac_q <= duc_pkg::CODE_ZERO;
        end else if (ce_i) begin
            inp_q <= inp_d;
            dac_q <= dac_d;
        end
    end

    assign input_code_o = inp_q;
    assign dac_code_o   = dac_q;
endmodule : duc_channel

/* File: core/duc_ctrl.sv */
// Top of the converter update and reset control: command decode, strobe, resets, reference.
`timescale 1ns/100ps
// Behaviour
// - Command 1 loads input register; DAC register too only while strobe low.
// - Command 2 copies input register to DAC register; input unchanged.
// - Command 3 writes both input and DAC registers regardless of strobe.
// - Strobe falling edge copies input to DAC on every unmasked channel.
// - Strobe held low makes mask bits irrelevant for updates.
// - Reset pin low clears outputs to zero or midscale per select pin.
// - After reset release outputs hold cleared code until new write.
// - While reset pin is low no output update is accepted.
// - Command 6 returns converter to its power-on reset code.
// - During power-on reset, strobe and reset pin activity is ignored.
// - Power-up level is zero with select low, midscale with select high.
// - Outputs keep power-on level until a valid write arrives.
// - Command 7 sets the reference from data bit zero.
// - Internal reference is enabled after power-up.
// - Data bit zero one turns reference off, zero turns it on.
// - Top four bits of the 24-bit word are the command code.
// - Command 1 with strobe low updates both registers when the word completes.
// - Set mask bit makes a channel ignore strobe; mask resets to zero.
module duc_ctrl (
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic        ce_i,
    input  wire logic        word_valid_i,
    input  wire logic [23:0] word_i,
    input  wire logic        load_strobe_n_i,
    input  wire logic        reset_pin_n_i,
    input  wire logic        reset_level_select_i,
    output logic      [11:0] dac_a_code_o,
    output logic      [11:0] dac_b_code_o,
    output logic      [11:0] input_a_code_o,
    output logic      [11:0] input_b_code_o,
    output logic             ref_enable_o,
    output logic      [1:0]  load_mask_o,
    output logic             por_busy_o
);
    duc_pkg::duc_word_type w;
    logic [1:0]  sel;
    logic [11:0] clear_code;
    logic [11:0] code [duc_pkg::NUM_CHAN];
    logic [11:0] inp [duc_pkg::NUM_CHAN];
    logic [11:0] dac [duc_pkg::NUM_CHAN];

    logic [4:0]  por_cnt_q;
    logic [4:0]  por_cnt_d;
    logic        strobe_q;
    logic        strobe_d;
    logic [1:0]  mask_q;
    logic [1:0]  mask_d;
    logic        ref_dis_q;
    logic        ref_dis_d;
    logic [11:0] por_code_q;
    logic [11:0] por_code_d;

    logic        por_busy;
    logic        hw_rst;
    logic        accept;
    logic        strobe_fall;
    logic        clear;
    logic [1:0]  ld_in;
    logic [1:0]  ld_dac_new;
    logic [1:0]  copy;

    assign w          = word_i;
    assign sel        = {w.addr[duc_pkg::ADDR_B_BIT], w.addr[duc_pkg::ADDR_A_BIT]};
    assign por_busy   = por_cnt_q != 5'(duc_pkg::POR_CYC);
    assign hw_rst     = !reset_pin_n_i && !por_busy;
    assign accept     = word_valid_i && !por_busy && !hw_rst;
    assign strobe_fall = strobe_q && !load_strobe_n_i && !por_busy && !hw_rst;
    assign clear_code = reset_level_select_i ? duc_pkg::CODE_MID : duc_pkg::CODE_ZERO;

    // Clear during power-on settling, hardware reset, or the software reset command.
    always_comb begin
        clear = por_busy || hw_rst;
        if (accept && w.cmd == duc_pkg::CMD_SOFT_RST) begin
            clear = 1'b1;
        end
    end

    always_comb begin
        ld_in      = 2'h0;
        ld_dac_new = 2'h0;
        copy       = 2'h0;
        if (accept) begin
            unique case (w.cmd)
                duc_pkg::CMD_WR_INPUT: begin
                    ld_in = sel;
                    if (!load_strobe_n_i) begin
                        ld_dac_new = sel;
                    end
                end
                duc_pkg::CMD_UPD_DAC: copy = sel;
                duc_pkg::CMD_WR_UPD: begin
                    ld_in      = sel;
                    ld_dac_new = sel;
                end
                default: ;
            endcase
        end
        // Masked channels ignore the falling edge; a held-low strobe has no edge.
        if (strobe_fall) begin
            copy = copy | ~mask_q;
        end
    end

    always_comb begin
        por_cnt_d  = por_busy ? por_cnt_q + 5'h01 : por_cnt_q;
        strobe_d   = load_strobe_n_i;
        mask_d     = mask_q;
        ref_dis_d  = ref_dis_q;
        por_code_d = por_code_q;
        if (por_busy) begin
            por_code_d = clear_code;
        end
        if (clear) begin
            mask_d    = duc_pkg::MASK_RESET;
            ref_dis_d = duc_pkg::REF_DIS_RESET;
        end else if (accept) begin
            if (w.cmd == duc_pkg::CMD_LOAD_MASK) begin
                mask_d = {w.data[duc_pkg::MASK_B_BIT], w.data[duc_pkg::MASK_A_BIT]};
            end
            if (w.cmd == duc_pkg::CMD_REF_SETUP) begin
                ref_dis_d = w.data[duc_pkg::REF_BIT];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            por_cnt_q  <= 5'h00;
            strobe_q   <= 1'b1;
            mask_q     <= duc_pkg::MASK_RESET;
            ref_dis_q  <= duc_pkg::REF_DIS_RESET;
            por_code_q <= duc_pkg::CODE_ZERO;
        end else if (ce_i) begin
            por_cnt_q  <= por_cnt_d;
            strobe_q   <= strobe_d;
            mask_q     <= mask_d;
            ref_dis_q  <= ref_dis_d;
            por_code_q <= por_code_d;
        end
    end

    // Software reset returns to the power-on code latched at power-up.
    logic [11:0] chan_clear_code;
    assign chan_clear_code = (por_busy || hw_rst) ? clear_code : por_code_q;

    genvar gi;
    generate
        for (gi = 0; gi < duc_pkg::NUM_CHAN; gi++) begin : g_chan
            assign code[gi] = w.data[duc_pkg::DATA_MSB:duc_pkg::DATA_LSB];
            duc_channel u_chan (
                .mclk_i         (mclk_i),
                .rstn_i         (rstn_i),
                .ce_i           (ce_i),
                .clear_i        (clear),
                .clear_code_i   (chan_clear_code),
                .load_input_i   (ld_in[gi]),
                .load_dac_new_i (ld_dac_new[gi]),
                .copy_i         (copy[gi]),
                .code_i         (code[gi]),
                .input_code_o   (inp[gi]),
                .dac_code_o     (dac[gi])
            );
        end
    endgenerate

    assign dac_a_code_o   = dac[0];
    assign dac_b_code_o   = dac[1];
    assign input_a_code_o = inp[0];
    assign input_b_code_o = inp[1];
    assign ref_enable_o   = !ref_dis_q;
    assign load_mask_o    = mask_q;
    assign por_busy_o     = por_busy;

    hold_reset_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ce_i && hw_rst |=> $stable(dac_a_code_o) || dac_a_code_o == $past(clear_code))
        else $error("DAC A changed to a non-clear code during reset.");
    cmd_one_hold_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ce_i && accept && w.cmd == 4'h1 && load_strobe_n_i && !strobe_fall && w.addr == 4'h1
        |=> $stable(dac_a_code_o) && input_a_code_o == $past(w.data[15:4]))
        else $error("Command one with strobe high changed DAC A.");
    cmd_one_low_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ce_i && accept && w.cmd == 4'h1 && !load_strobe_n_i && w.addr == 4'h1
        |=> dac_a_code_o == $past(w.data[15:4]))
        else $error("Command one with strobe low did not update DAC A.");
    cmd_two_copy_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ce_i && accept && w.cmd == 4'h2 && w.addr == 4'h8
        |=> dac_b_code_o == $past(input_b_code_o) && $stable(input_b_code_o))
        else $error("Command two did not copy channel B.");
    cmd_three_both_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ce_i && accept && w.cmd == 4'h3 && w.addr == 4'h9
        |=> dac_a_code_o == $past(w.data[15:4]) && input_b_code_o == $past(w.data[15:4]))
        else $error("Command three did not write both registers.");
    strobe_edge_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ce_i && strobe_fall && !mask_q[1] && !accept |=> dac_b_code_o == $past(input_b_code_o))
        else $error("Strobe edge did not copy unmasked channel B.");
    mask_block_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ce_i && strobe_fall && mask_q[0] && !word_valid_i |=> $stable(dac_a_code_o))
        else $error("Masked channel A responded to strobe.");
    ref_setup_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ce_i && accept && w.cmd == 4'h7 |=> ref_enable_o == !$past(w.data[0]))
        else $error("Reference setup bit not applied.");
    power_level_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ce_i && por_busy |=> dac_a_code_o == (reset_level_select_i ? 12'h800 : 12'h000)
            || $changed(reset_level_select_i))
        else $error("Power-up code does not follow level select.");
    ref_default_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ce_i && clear |=> ref_enable_o)
        else $error("Reference not enabled after a clear.");
    undecoded_cmd_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ce_i && accept && w.cmd inside {4'h0, 4'h4, [4'h8:4'hF]} && !strobe_fall
        |=> $stable(dac_a_code_o) && $stable(dac_b_code_o) && $stable(input_a_code_o)
            && $stable(input_b_code_o) && $stable(load_mask_o) && $stable(ref_enable_o))
        else $error("Undecoded command changed state.");
    soft_reset_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ce_i && accept && w.cmd == 4'h6
        |=> dac_a_code_o == $past(por_code_q) && dac_b_code_o == $past(por_code_q))
        else $error("Software reset did not restore the power-on code.");
    enable_freeze_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !ce_i |=> $stable(dac_a_code_o) && $stable(input_b_code_o) && $stable(por_busy_o))
        else $error("State moved while the clock enable was low.");
endmodule : duc_ctrl

/* File: dv/duc_host.sv */
// Host model that drives command words, the load strobe pin and the hardware reset pin.
`timescale 1ns/100ps
module duc_host (
    input  wire logic        mclk_i,
    output logic             word_valid_o,
    output logic      [23:0] word_o,
    output logic             load_strobe_n_o,
    output logic             reset_pin_n_o
);
    initial begin
        word_valid_o    = 1'b0;
        word_o          = 24'h000000;
        load_strobe_n_o = 1'b1;
        reset_pin_n_o   = 1'b1;
    end

    // A released word bus shows the inverse of its last value, so stale data never looks fresh.
    task automatic send_word(input logic [23:0] w);
        @(negedge mclk_i);
        word_o       = w;
        word_valid_o = 1'b1;
        @(negedge mclk_i);
        word_valid_o = 1'b0;
        word_o       = ~w;
    endtask : send_word

    task automatic set_strobe(input logic lvl);
        @(negedge mclk_i);
        load_strobe_n_o = lvl;
    endtask : set_strobe

    task automatic pulse_reset(input int unsigned cyc);
        int unsigned n;
        n = (cyc < duc_pkg::RST_MIN_CYC) ? duc_pkg::RST_MIN_CYC : cyc;
        @(negedge mclk_i);
        reset_pin_n_o = 1'b0;
        repeat (n) @(negedge mclk_i);
        reset_pin_n_o = 1'b1;
    endtask : pulse_reset
endmodule : duc_host

/* File: dv/dac_update_reset_control_tb.sv */
// Self-checking testbench for the converter update and reset control block.
`timescale 1ns/100ps
module dac_update_reset_control_tb;
    logic        mclk, rstn, ce, sel, wv, strobe_n, rpin_n, ref_en, por_busy, e_ref;
    logic [23:0] word;
    logic [11:0] dac_a, dac_b, in_a, in_b, e_por;
    logic [11:0] e_in [2];
    logic [11:0] e_dac [2];
    logic [1:0]  mask, e_mask;
    int          n_mismatch, n_tests;

    duc_host u_duc_host (.mclk_i(mclk), .word_valid_o(wv), .word_o(word), .load_strobe_n_o(strobe_n),
                         .reset_pin_n_o(rpin_n));
    duc_ctrl u_duc_ctrl (.mclk_i(mclk), .rstn_i(rstn), .ce_i(ce), .word_valid_i(wv), .word_i(word),
                         .load_strobe_n_i(strobe_n), .reset_pin_n_i(rpin_n), .reset_level_select_i(sel),
                         .dac_a_code_o(dac_a), .dac_b_code_o(dac_b), .input_a_code_o(in_a),
                         .input_b_code_o(in_b), .ref_enable_o(ref_en), .load_mask_o(mask),
                         .por_busy_o(por_busy));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic close_out();
        $display("counts: %0d checks, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic check_regs(input string t);
        check("input_a", in_a, e_in[0]);
        check("input_b", in_b, e_in[1]);
        check("dac_a", dac_a, e_dac[0]);
        check("dac_b", dac_b, e_dac[1]);
        check("mask", {10'h000, mask}, {10'h000, e_mask});
        check("ref", {11'h000, ref_en}, {11'h000, e_ref});
        $display("test %s done", t);
    endtask : check_regs

    function automatic void clr(input logic [11:0] code);
        e_in   = '{code, code};
        e_dac  = '{code, code};
        e_mask = 2'h0;
        e_ref  = 1'b1;
    endfunction : clr

    function automatic void model(input logic [23:0] w, input logic low);
        duc_pkg::duc_word_type c;
        logic [1:0] hit;
        c = w;
        hit = {c.addr[duc_pkg::ADDR_B_BIT], c.addr[duc_pkg::ADDR_A_BIT]};
        for (int i = 0; i < 2; i++) begin
            if (hit[i] && c.cmd inside {duc_pkg::CMD_WR_INPUT, duc_pkg::CMD_WR_UPD}) begin
                e_in[i] = c.data[15:4];
                if (low || c.cmd == duc_pkg::CMD_WR_UPD) e_dac[i] = c.data[15:4];
            end
            if (hit[i] && c.cmd == duc_pkg::CMD_UPD_DAC) e_dac[i] = e_in[i];
        end
        if (c.cmd == duc_pkg::CMD_LOAD_MASK) e_mask = {c.data[3], c.data[0]};
        if (c.cmd == duc_pkg::CMD_REF_SETUP) e_ref = ~c.data[0];
        if (c.cmd == duc_pkg::CMD_SOFT_RST) clr(e_por);
    endfunction : model

    task automatic tx(input logic [3:0] cmd, input logic [3:0] addr, input logic [15:0] data);
        u_duc_host.send_word({cmd, addr, data});
        model({cmd, addr, data}, !strobe_n);
        @(negedge mclk);
    endtask : tx

    // The strobe is left low for four cycles so its edge is surely seen before it rises again.
    task automatic strobe_pulse();
        u_duc_host.set_strobe(1'b0);
        repeat (3) @(negedge mclk);
        for (int i = 0; i < 2; i++) if (!e_mask[i]) e_dac[i] = e_in[i];
        u_duc_host.set_strobe(1'b1);
    endtask : strobe_pulse

    task automatic power_up(input logic s);
        rstn = 1'b0;
        sel  = s;
        repeat (4) @(negedge mclk);
        rstn = 1'b1;
        check("por_busy_high", {11'h000, por_busy}, 12'h001);
        u_duc_host.send_word({duc_pkg::CMD_WR_UPD, 4'h9, 16'($urandom())});
        u_duc_host.set_strobe(1'b0);
        u_duc_host.set_strobe(1'b1);
        for (int n = 0; n < 64 && por_busy !== 1'b0; n++) @(negedge mclk);
        check("por_busy", {11'h000, por_busy}, 12'h000);
        e_por = s ? duc_pkg::CODE_MID : duc_pkg::CODE_ZERO;
        clr(e_por);
        check_regs("power_up");
    endtask : power_up

    initial begin
        #(20000 * 10);
        n_mismatch++;
        close_out();
    end

    initial begin
        logic s0;
        ce   = 1'b1;
        void'($urandom(52698));
        s0 = 1'($urandom());
        for (int p = 0; p < 2; p++) begin
            power_up(s0 ^ 1'(p));
            tx(duc_pkg::CMD_WR_INPUT, 4'h9, 16'($urandom()));
            check_regs("write_input_strobe_high");
            strobe_pulse();
            check_regs("strobe_edge");
            tx(duc_pkg::CMD_LOAD_MASK, 4'h0, 16'h0001);
            tx(duc_pkg::CMD_WR_INPUT, 4'h9, 16'($urandom()));
            strobe_pulse();
            check_regs("masked_edge");
            u_duc_host.set_strobe(1'b0);
            tx(duc_pkg::CMD_WR_INPUT, 4'h1, 16'($urandom()));
            tx(duc_pkg::CMD_WR_INPUT, 4'h8, 16'($urandom()));
            check_regs("strobe_held_low");
            u_duc_host.set_strobe(1'b1);
            tx(duc_pkg::CMD_WR_INPUT, 4'h1, 16'($urandom()));
            check_regs("write_input_a_strobe_high");
            tx(duc_pkg::CMD_WR_INPUT, 4'h9, 16'($urandom()));
            tx(duc_pkg::CMD_UPD_DAC, 4'h1, 16'($urandom()));
            check_regs("copy_a");
            tx(duc_pkg::CMD_UPD_DAC, 4'h8, 16'($urandom()));
            check_regs("copy_b");
            tx(duc_pkg::CMD_WR_UPD, 4'h8, 16'($urandom()));
            check_regs("write_update_b");
            tx(duc_pkg::CMD_REF_SETUP, 4'h0, 16'h0001);
            check_regs("ref_off");
            tx(duc_pkg::CMD_REF_SETUP, 4'h0, 16'hFFFE);
            check_regs("ref_on");
            for (int k = 0; k < 16; k++) if (k == 0 || k == 4 || k >= 8) tx(4'(k), 4'h9, 16'($urandom()));
            check_regs("undecoded");
            // A word offered while the clock enable is low must leave no trace.
            ce = 1'b0;
            u_duc_host.send_word({duc_pkg::CMD_WR_UPD, 4'h9, 16'($urandom())});
            ce = 1'b1;
            check_regs("enable_low");
            tx(duc_pkg::CMD_LOAD_MASK, 4'h0, 16'h0009);
            tx(duc_pkg::CMD_REF_SETUP, 4'h0, 16'h0001);
            sel = ~sel;
            fork
                u_duc_host.pulse_reset(4);
                begin
                    repeat (2) @(negedge mclk);
                    u_duc_host.send_word({duc_pkg::CMD_WR_UPD, 4'h9, 16'($urandom())});
                end
            join
            clr(sel ? duc_pkg::CODE_MID : duc_pkg::CODE_ZERO);
            repeat (5) @(negedge mclk);
            check_regs("reset_pin");
            tx(duc_pkg::CMD_WR_UPD, 4'h9, 16'($urandom()));
            tx(duc_pkg::CMD_SOFT_RST, 4'h0, 16'h0000);
            check_regs("soft_reset");
        end
        close_out();
    end
endmodule : dac_update_reset_control_tb
